// ---- hdl/secondary_bus_port_control.sv ----
// secondary side bus control: abort, turnaround, parity, arbiter, reset, clocks
`timescale 1ns/1ps
module secondary_bus_port_control
  import sec_port_pkg::*;
#(
  parameter int HOLD_CYC = SEC_RST_HOLD
) (
  input  wire logic                clk_i,                         // primary clock
  input  wire logic                rstn_i,                        // primary reset, low
  input  wire logic                sec_bus_clock_in_i,            // secondary clock
  input  wire logic                sec_reset_sw_i,                // software reset bit
  input  wire logic [N_CLKOUT-1:0] clk_disable_i,                 // software clock stops
  input  wire logic                clock_mask_serial_in_i,        // serial mask data pin
  input  wire logic                mask_shift_clk_i,              // serial mask clock pin
  input  wire logic                pri_fast_capable_i,            // primary speed pin
  input  wire logic                sec_fast_capable_i,            // secondary speed pin in
  output logic                     sec_fast_capable_o,            // speed pin drive
  output logic                     sec_fast_capable_oe_o,         // speed pin enable
  output logic                     sec_reset_n_o,                 // secondary reset, low
  output logic [N_CLKOUT-1:0]      sec_bus_clock_out_o,           // secondary clocks
  output logic [N_CLKOUT-1:0]      clock_mask_o,                  // received serial mask
  input  wire logic                sec_central_function_strap_n_i, // arbiter strap
  input  wire logic [N_REQ-1:0]    sec_req_n_i,                   // requests, low
  output logic [N_REQ-1:0]         sec_gnt_n_o,                   // grants, low
  input  wire logic                bridge_req_i,                  // bridge wants bus
  output logic                     bridge_gnt_o,                  // bridge owns bus
  input  wire logic                sec_frame_n_i,                 // frame pin
  input  wire logic                sec_irdy_n_i,                  // initiator ready pin
  input  wire logic                sec_target_claim_n_i,          // claim pin in
  input  wire logic                sec_stop_n_i,                  // stop pin in
  input  wire logic                sec_system_fault_n_i,          // system fault pin
  input  wire logic [31:0]         sec_ad_i,                      // address/data pins
  input  wire logic [3:0]          sec_cmd_byte_en_i,             // command/byte pins
  input  wire logic                sec_parity_i,                  // parity pin
  output sec_adcp_t                sec_drive_o,                   // ad/cbe/par drive
  output logic                     sec_drive_oe_o,                // ad/cbe/par enable
  input  wire logic                mst_frame_start_i,             // our frame asserted
  input  wire logic                mst_active_i,                  // we are initiator
  input  wire logic                mst_lock_i,                    // locked sequence
  input  wire logic                tgt_claim_i,                   // we claim as target
  input  wire logic                tgt_stop_i,                    // we stop as target
  input  wire logic                data_rx_i,                     // data phase received
  output logic                     sec_target_claim_n_o,          // claim drive
  output logic                     sec_target_claim_oe_o,         // claim enable
  output logic                     sec_stop_n_o,                  // stop drive
  output logic                     sec_stop_oe_o,                 // stop enable
  output logic                     sec_data_parity_fault_n_o,     // parity fault drive
  output logic                     sec_data_parity_fault_oe_o,    // parity fault enable
  output logic                     sec_lock_n_o,                  // lock drive
  output logic                     sec_lock_oe_o,                 // lock enable
  output logic                     master_abort_o,                // abort pulse
  output logic                     mst_terminate_o,               // stop honoured pulse
  output logic                     sys_fault_o,                   // system fault seen
  output logic                     sec_fast_o                     // fast bus allowed
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("secondary_bus_port_control: HOLD_CYC must be at least 1");
  end

  // ---------------- primary clock domain ----------------
  typedef struct packed {
    logic                sec_rst_n;
    logic [HW-1:0]       hold;
    logic                ph;
    logic [N_CLKOUT-1:0] clk_out;
    logic [N_CLKOUT-1:0] mask;
    logic [3:0]          mask_cnt;
    logic                mclk_d;
    logic                fast_oe;
  } pri_t;
  pri_t p_reg, p_next;

  logic [1:0]          pin_s;   // {mask clock, mask data}
  logic [N_CLKOUT-1:0] dis_eff;
  logic                mask_edge;

  // mask pins are not on our clock
  sync_2ff #(.W(2)) u_pin_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({mask_shift_clk_i, clock_mask_serial_in_i}),
    .q_o    (pin_s)
  );

  assign dis_eff   = clk_disable_i | p_reg.mask;
  assign mask_edge = pin_s[1] && !p_reg.mclk_d;

  always_comb begin
    p_next = p_reg;
    // divided clock fans out to ten outputs
    p_next.ph = ~p_reg.ph;
    p_next.clk_out = {N_CLKOUT{p_next.ph}} & ~dis_eff;
    p_next.fast_oe = ~pri_fast_capable_i;
    if (p_reg.hold != '0) begin
      p_next.hold = p_reg.hold - HW'(1);
    end
    // reset from primary or software; hold leaves room for the mask
    p_next.sec_rst_n = !sec_reset_sw_i && (p_reg.hold == '0);
    // shift the serial mask while secondary reset is held
    p_next.mclk_d = pin_s[1];
    if (!p_reg.sec_rst_n && p_reg.mask_cnt != 4'(N_CLKOUT) && mask_edge) begin
      p_next.mask     = {p_reg.mask[N_CLKOUT-2:0], pin_s[0]};
      p_next.mask_cnt = p_reg.mask_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p_reg.sec_rst_n <= 1'b0;
      p_reg.hold      <= HW'(HOLD_CYC);
      p_reg.ph        <= 1'b0;
      p_reg.clk_out   <= '0;
      p_reg.mask      <= CLK_MASK_RST;
      p_reg.mask_cnt  <= 4'h0;
      p_reg.mclk_d    <= 1'b0;
      p_reg.fast_oe   <= 1'b0;
    end else begin
      p_reg <= p_next;
    end
  end

  assign sec_reset_n_o         = p_reg.sec_rst_n;
  assign sec_bus_clock_out_o   = p_reg.clk_out;
  assign clock_mask_o          = p_reg.mask;
  assign sec_fast_capable_o    = 1'b0; // open drain: only ever pulls low
  assign sec_fast_capable_oe_o = p_reg.fast_oe;

  // ---------------- secondary clock domain ----------------
  // bus side timed from the secondary clock
  typedef struct packed {
    ma_state_t         ma;
    logic [2:0]        ma_cnt;
    logic              abort;
    logic              term;
    logic              rx_pend;
    logic [35:0]       cap;
    logic              perr_req;
    logic [N_TURN-1:0] t_o;
    logic [N_TURN-1:0] t_oe;
    logic              ext_mode;
    logic              sys_fault;
    logic              fast;
    logic [N_REQ-1:0]  gnt_n;
    logic              bridge_gnt;
    sec_adcp_t         ad;
    logic              ad_oe;
  } sec_t;
  sec_t s_reg, s_next;

  logic [1:0]        rs_s;    // {strap, secondary reset released}
  logic              srst;
  logic              idle;
  logic [N_GNT-1:0]  arb_gnt;
  logic [N_TURN-1:0] treq;

  // reset level and strap cross into the secondary domain
  sync_2ff #(.W(2)) u_sec_sync (
    .clk_i  (sec_bus_clock_in_i),
    .rstn_i (rstn_i),
    .d_i    ({sec_central_function_strap_n_i, p_reg.sec_rst_n}),
    .q_o    (rs_s)
  );

  // a cleared synchroniser reads as reset, so the bus side starts quiet
  assign srst = !rs_s[0];
  assign idle = sec_frame_n_i && sec_irdy_n_i;
  assign treq = {mst_lock_i, s_reg.perr_req, tgt_stop_i, tgt_claim_i};

  // active-low requests, bridge in the top slot
  sec_bus_arbiter #(.N(N_GNT)) u_arb (
    .clk_i    (sec_bus_clock_in_i),
    .rstn_i   (rstn_i),
    .enable_i (!srst && !s_reg.ext_mode),
    .idle_i   (idle),
    .req_i    ({bridge_req_i, ~sec_req_n_i}),
    .gnt_o    (arb_gnt)
  );

  always_comb begin
    s_next = s_reg;
    // strap caught while secondary reset is held
    s_next.ext_mode = srst ? rs_s[1] : s_reg.ext_mode;
    // count claim wait after our frame
    s_next.abort = 1'b0;
    case (s_reg.ma)
      MA_IDLE: begin
        if (mst_frame_start_i) begin
          s_next.ma     = MA_WAIT;
          s_next.ma_cnt = 3'h0;
        end
      end
      MA_WAIT: begin
        if (!sec_target_claim_n_i) begin
          s_next.ma = MA_CLAIMED;
        end else if (s_reg.ma_cnt == 3'(ABORT_CYCLES - 1)) begin
          s_next.abort = 1'b1;
          s_next.ma    = MA_IDLE;
        end else begin
          s_next.ma_cnt = s_reg.ma_cnt + 3'h1;
        end
      end
      MA_CLAIMED: begin
        if (!mst_active_i) begin
          s_next.ma = MA_IDLE;
        end
      end
      default: s_next.ma = MA_IDLE;
    endcase
    if (srst) begin
      s_next.ma = MA_IDLE;
    end
    s_next.term = mst_active_i && !sec_stop_n_i && !srst;
    // parity is checked a clock after the data
    s_next.rx_pend = data_rx_i;
    if (data_rx_i) begin
      s_next.cap = {sec_ad_i, sec_cmd_byte_en_i};
    end
    s_next.perr_req = s_reg.rx_pend && (^{s_reg.cap, sec_parity_i}) && !srst;
    // assert, then one inactive clock, then release
    for (int i = 0; i < N_TURN; i++) begin
      if (srst) begin
        s_next.t_o[i]  = 1'b1;
        s_next.t_oe[i] = 1'b0;
      end else if (treq[i]) begin
        s_next.t_o[i]  = 1'b0;
        s_next.t_oe[i] = 1'b1;
      end else if (s_reg.t_oe[i] && !s_reg.t_o[i]) begin
        s_next.t_o[i]  = 1'b1;
        s_next.t_oe[i] = 1'b1;
      end else begin
        s_next.t_o[i]  = 1'b1;
        s_next.t_oe[i] = 1'b0;
      end
    end
    s_next.sys_fault = !sec_system_fault_n_i;
    s_next.fast = sec_fast_capable_i;
    if (srst) begin
      s_next.gnt_n      = '1;
      s_next.bridge_gnt = 1'b0;
    end else if (s_reg.ext_mode) begin
      s_next.gnt_n      = {{(N_REQ-1){1'b1}}, ~bridge_req_i};
      s_next.bridge_gnt = !sec_req_n_i[0];
    end else begin
      s_next.gnt_n      = ~arb_gnt[N_REQ-1:0];
      s_next.bridge_gnt = arb_gnt[BRIDGE_IDX];
    end
    // zeros on the bus in reset
    s_next.ad    = '0;
    s_next.ad_oe = srst || (idle && s_reg.bridge_gnt);
  end

  always_ff @(posedge sec_bus_clock_in_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg            <= '0;
      s_reg.ma         <= MA_IDLE;
      s_reg.t_o        <= '1;
      s_reg.gnt_n      <= '1;
      s_reg.ad_oe      <= 1'b1; // zeros on the bus through primary reset
    end else begin
      s_reg <= s_next;
    end
  end

  assign sec_target_claim_n_o       = s_reg.t_o[TURN_CLAIM];
  assign sec_target_claim_oe_o      = s_reg.t_oe[TURN_CLAIM];
  assign sec_stop_n_o               = s_reg.t_o[TURN_STOP];
  assign sec_stop_oe_o              = s_reg.t_oe[TURN_STOP];
  assign sec_data_parity_fault_n_o  = s_reg.t_o[TURN_PERR];
  assign sec_data_parity_fault_oe_o = s_reg.t_oe[TURN_PERR];
  assign sec_lock_n_o               = s_reg.t_o[TURN_LOCK];
  assign sec_lock_oe_o              = s_reg.t_oe[TURN_LOCK];
  assign sec_gnt_n_o                = s_reg.gnt_n;
  assign bridge_gnt_o               = s_reg.bridge_gnt;
  assign sec_drive_o                = s_reg.ad;
  assign sec_drive_oe_o             = s_reg.ad_oe;
  assign master_abort_o             = s_reg.abort;
  assign mst_terminate_o            = s_reg.term;
  assign sys_fault_o                = s_reg.sys_fault;
  assign sec_fast_o                 = s_reg.fast;

  // ---------------- checks ----------------
  sequence s_unclaimed;
    mst_frame_start_i && s_reg.ma == MA_IDLE && !srst ##1
      (sec_target_claim_n_i && !srst)[*5];
  endsequence
  a_master_abort: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
    s_unclaimed |-> ##1 master_abort_o) else $error("master abort missing");

  a_stop_honour: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
    mst_active_i && !sec_stop_n_i && !srst |=> mst_terminate_o) else $error("stop ignored");

  for (genvar g = 0; g < N_TURN; g++) begin : g_turn_chk
    sequence s_release;
      s_reg.t_oe[g] && !s_reg.t_o[g] && !treq[g] && !srst;
    endsequence
    a_turn_high: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
      s_release |=> s_reg.t_oe[g] && s_reg.t_o[g]) else $error("released without high clock");
    a_turn_float: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
      $fell(s_reg.t_oe[g]) |-> $past(s_reg.t_o[g])) else $error("floated while asserted");
  end

  a_parity_flag: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
    s_reg.rx_pend && (^{s_reg.cap, sec_parity_i}) && !srst ##1 !srst |=>
      sec_data_parity_fault_oe_o && !sec_data_parity_fault_n_o) else $error("parity fault missed");

  a_reset_float: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
    srst |=> !sec_target_claim_oe_o && !sec_stop_oe_o && sec_drive_oe_o && sec_drive_o == '0)
    else $error("bus not quiet in reset");

  a_ext_mode: assert property (@(posedge sec_bus_clock_in_i) disable iff (!rstn_i)
    s_reg.ext_mode && !srst |=> sec_gnt_n_o[N_REQ-1:1] == '1 && sec_gnt_n_o[0] == !$past(bridge_req_i))
    else $error("external mode slot zero wrong");

  a_sec_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sec_reset_sw_i |=> !sec_reset_n_o) else $error("secondary reset not asserted");

  a_speed_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !pri_fast_capable_i |=> sec_fast_capable_oe_o && !sec_fast_capable_o) else $error("speed line free");

  a_clock_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> (sec_bus_clock_out_o & $past(dis_eff)) == '0) else $error("disabled clock running");

  a_mask_shift: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !p_reg.sec_rst_n && p_reg.mask_cnt != 4'(N_CLKOUT) && mask_edge |=>
      clock_mask_o[0] == $past(pin_s[0])) else $error("mask bit not shifted");
endmodule // secondary_bus_port_control

// ---- hdl/sec_port_pkg.sv ----
// constants and carrier types for the secondary bus port control block
// Summary of operation
// - master abort after 5 unclaimed cycles
// - drive inactive one clock before release
// - target stop ends our current transaction
// - lock held across a locked sequence
// - assert parity fault on received bad data
// - grant stays off two clocks between grants
// - park drive on idle bus with grant
// - secondary reset follows primary or software
// - in reset float controls, drive zeros
// - speed line high allows fast bus
// - slow primary forces speed line low
// - strap low selects internal arbiter
// - external mode swaps request/grant zero
// - secondary logic runs on secondary clock
// - ten clock outputs from primary clock
// - software bits stop single clock outputs
// - serial mask can also stop clocks
// - serial mask shifts in during secondary reset
package sec_port_pkg;
  localparam int N_REQ          = 9;   // external requesters
  localparam int N_GNT          = 10;  // requesters plus the bridge
  localparam int BRIDGE_IDX     = 9;   // arbiter slot of the bridge
  localparam int N_CLKOUT       = 10;
  localparam int ABORT_CYCLES   = 5;   // claim wait after frame
  localparam int GNT_GAP_CYCLES = 2;   // idle grant clocks
  localparam int SEC_RST_HOLD   = 256; // default hold after primary reset
  localparam int N_TURN         = 4;
  localparam int TURN_CLAIM     = 0;
  localparam int TURN_STOP      = 1;
  localparam int TURN_PERR      = 2;
  localparam int TURN_LOCK      = 3;
  localparam logic [9:0] CLK_MASK_RST = 10'h000;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe;
    logic        par;
  } sec_adcp_t;

  typedef enum logic [1:0] {MA_IDLE, MA_WAIT, MA_CLAIMED} ma_state_t;
  typedef enum logic [0:0] {ARB_GAP, ARB_GRANT} arb_state_t;
endpackage

// ---- hdl/sync_2ff.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_2ff
  import sec_port_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // destination clock
  input  wire logic         rstn_i, // async reset, active low
  input  wire logic [W-1:0] d_i,    // foreign level
  output logic      [W-1:0] q_o     // synchronised level
);
  if (W < 1) begin : g_bad_w
    $error("sync_2ff: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t r_reg, r_next;

  // first stage feeds only the second stage
  always_comb begin
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;
endmodule // sync_2ff

// ---- hdl/sec_bus_arbiter.sv ----
// round-robin secondary bus arbiter with bridge parking
`timescale 1ns/1ps
module sec_bus_arbiter
  import sec_port_pkg::*;
#(
  parameter int N = N_GNT
) (
  input  wire logic         clk_i,    // secondary clock
  input  wire logic         rstn_i,   // async reset, active low
  input  wire logic         enable_i, // internal arbiter in use
  input  wire logic         idle_i,   // bus idle
  input  wire logic [N-1:0] req_i,    // requests, active high
  output logic      [N-1:0] gnt_o     // grants, active high
);
  localparam int IW = $clog2(N);
  if (N < 2 || BRIDGE_IDX >= N) begin : g_bad_n
    $error("sec_bus_arbiter: N must hold the bridge slot");
  end

  typedef struct packed {
    arb_state_t  st;
    logic [N-1:0] gnt;
    logic [IW-1:0] owner;
    logic [IW-1:0] last;
    logic [1:0]   gap;
  } arb_t;
  arb_t r_reg, r_next;

  // next owner after the last one, parking on the bridge
  function automatic logic [IW-1:0] pick(input logic [N-1:0] req, input logic [IW-1:0] last);
    logic [IW-1:0] w;
    logic          found;
    int            idx;
    w = IW'(BRIDGE_IDX);
    found = 1'b0;
    for (int i = 1; i <= N; i++) begin
      idx = (int'(last) + i) % N;
      if (!found && req[idx]) begin
        w = IW'(idx);
        found = 1'b1;
      end
    end
    return w;
  endfunction

  logic [IW-1:0] win;
  assign win = pick(req_i, r_reg.last);

  // regrant only on an idle bus; every change passes the gap state
  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      ARB_GRANT: begin
        if (!enable_i || (idle_i && win != r_reg.owner)) begin
          r_next.gnt = '0;
          r_next.gap = 2'(GNT_GAP_CYCLES - 1);
          r_next.st  = ARB_GAP;
        end
      end
      ARB_GAP: begin
        if (r_reg.gap != 2'h0) begin
          r_next.gap = r_reg.gap - 2'h1;
        end else if (enable_i) begin
          r_next.gnt      = '0;
          r_next.gnt[win] = 1'b1;
          r_next.owner    = win;
          r_next.last     = win;
          r_next.st       = ARB_GRANT;
        end
      end
      default: r_next.st = ARB_GAP;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg.st    <= ARB_GAP;
      r_reg.gnt   <= '0;
      r_reg.owner <= IW'(BRIDGE_IDX);
      r_reg.last  <= IW'(BRIDGE_IDX);
      r_reg.gap   <= 2'h1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign gnt_o = r_reg.gnt;

  a_grant_onehot: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $onehot0(r_reg.gnt)) else $error("two grants asserted together");
  a_grant_gap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(|r_reg.gnt) |-> ##1 (r_reg.gnt == '0)) else $error("grant reasserted too soon");
endmodule // sec_bus_arbiter

// ---- bench/sec_agent_model.sv ----
// far-side target agent that claims our transactions after a chosen delay
`timescale 1ns/1ps
module sec_agent_model (
  input  wire logic sclk_i,    // secondary clock
  input  wire logic start_i,   // our frame starts
  input  wire logic [31:0] dly_i, // claim delay in cycles, 0 = never
  output logic      claim_n_o  // claim pin, pulled up
);
  int cnt = 0;
  // cycles since our frame began
  always @(posedge sclk_i) cnt <= start_i ? 1 : (cnt == 0 ? 0 : cnt + 1);
  // assert claim for two cycles from the delay, then drive it high
  always @(negedge sclk_i) claim_n_o <= !(dly_i != 0 && cnt >= dly_i && cnt < dly_i + 2);
  initial claim_n_o = 1;
endmodule // sec_agent_model

// ---- bench/test_secondary_bus_port_control.sv ----
// self-checking bench for the secondary bus port control block
`timescale 1ns/1ps
module test_secondary_bus_port_control;
  import sec_port_pkg::*;
  localparam int HOLD = 16; // short secondary reset hold
  logic clk_i = 0, rstn_i = 0, sec_bus_clock_in_i = 0, sec_reset_sw_i = 0, bridge_req_i = 0;
  logic clock_mask_serial_in_i = 0, mask_shift_clk_i = 0, pri_fast_capable_i = 1;
  logic sec_fast_capable_i = 1, sec_central_function_strap_n_i = 0, sec_frame_n_i = 1;
  logic sec_irdy_n_i = 1, sec_stop_n_i = 1, sec_system_fault_n_i = 1, sec_parity_i = 0;
  logic mst_frame_start_i = 0, mst_active_i = 0, mst_lock_i = 0, tgt_claim_i = 0;
  logic tgt_stop_i = 0, data_rx_i = 0, sec_target_claim_n_i, sec_fast_capable_o;
  logic [9:0] clk_disable_i = 0, sec_bus_clock_out_o, clock_mask_o, cv, mv;
  logic [8:0] sec_req_n_i = '1, sec_gnt_n_o;
  logic [31:0] sec_ad_i = 0;
  logic [3:0] sec_cmd_byte_en_i = 0;
  sec_adcp_t sec_drive_o;
  logic sec_fast_capable_oe_o, sec_reset_n_o, bridge_gnt_o, sec_drive_oe_o, master_abort_o;
  logic sec_target_claim_n_o, sec_target_claim_oe_o, sec_stop_n_o, sec_stop_oe_o;
  logic sec_data_parity_fault_n_o, sec_data_parity_fault_oe_o, sec_lock_n_o, sec_lock_oe_o;
  logic mst_terminate_o, sys_fault_o, sec_fast_o;
  int num_errors = 0, cmp_count = 0, seed = 81816, dly = 0, e, t, i, k;

  secondary_bus_port_control #(.HOLD_CYC(HOLD)) uut (.*);
  sec_agent_model agent (.sclk_i(sec_bus_clock_in_i), .start_i(mst_frame_start_i),
                         .dly_i(dly), .claim_n_o(sec_target_claim_n_i));

  // odd offset keeps secondary edges off the primary edges
  initial forever #10 clk_i = ~clk_i;
  initial begin
    #13 sec_bus_clock_in_i = 1;
    forever #32 sec_bus_clock_in_i = ~sec_bus_clock_in_i;
  end

  task ss(int n); repeat (n) @(negedge sec_bus_clock_in_i); endtask
  task ps(int n); repeat (n) @(negedge clk_i); endtask

  task automatic chk(string s, logic [31:0] x, logic [31:0] y);
    cmp_count++;
    if (x !== y) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", s, x, y);
    end
  endtask

  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // pin pair {drive, enable} of one turnaround line
  function automatic logic [1:0] tn(int j);
    return j == 0 ? {sec_target_claim_n_o, sec_target_claim_oe_o} :
           j == 1 ? {sec_stop_n_o, sec_stop_oe_o} : {sec_lock_n_o, sec_lock_oe_o};
  endfunction

  // wait for slot j to be granted, t = all-off cycles just before it
  task automatic wt(int j);
    logic [9:0] gv;
    t = 0;
    for (int n = 0; n < 20; n++) begin
      ss(1);
      gv = {bridge_gnt_o, ~sec_gnt_n_o};
      if (gv[j] === 1'b1) return;
      t = (gv === 0) ? t + 1 : 0;
    end
    chk("grant seen", 1, 0);
  endtask

  // grant exclusivity watched on every secondary cycle while secondary reset is off and the strap is low
  always @(negedge sec_bus_clock_in_i)
    if (sec_reset_n_o === 1'b1 && sec_central_function_strap_n_i === 1'b0)
    chk("one grant", 1, $countones({bridge_gnt_o, ~sec_gnt_n_o}) <= 1);

  // a hang counts as a mismatch
  initial begin
    #100000;
    num_errors++;
    test_done;
  end

  initial begin
    ps(4);
    rstn_i = 1;
    ps(HOLD - 1);
    chk("sec reset", 0, sec_reset_n_o);
    ps(8);
    chk("sec reset", 1, sec_reset_n_o);
    sec_reset_sw_i = 1;
    ps(12);
    chk("sec reset", 0, sec_reset_n_o);
    chk("zero drive", 1, sec_drive_oe_o && sec_drive_o === 0);
    chk("float", 0, {sec_target_claim_oe_o, sec_stop_oe_o, sec_lock_oe_o});
    // serial mask shifted in msb first while secondary reset is held
    mv = $random(seed);
    for (k = 9; k >= 0; k--) begin
      {mask_shift_clk_i, clock_mask_serial_in_i} = {1'b0, mv[k]};
      ps(3);
      mask_shift_clk_i = 1;
      ps(3);
    end
    chk("clock mask", mv, clock_mask_o);
    sec_reset_sw_i = 0;
    ps(HOLD + 8);
    chk("sec reset", 1, sec_reset_n_o);
    ss(5);
    $display("reset test done");
    // speed, fault and clock-stop levels from random stimulus
    for (k = 0; k < 4; k++) begin
      {pri_fast_capable_i, sec_fast_capable_i, sec_system_fault_n_i} = $random(seed);
      clk_disable_i = $random(seed);
      ss(3);
      chk("speed pull", {1'b0, !pri_fast_capable_i}, {sec_fast_capable_o, sec_fast_capable_oe_o});
      chk("fast", sec_fast_capable_i, sec_fast_o);
      chk("sys fault", !sec_system_fault_n_i, sys_fault_o);
      @(negedge clk_i) cv = sec_bus_clock_out_o;
      @(negedge clk_i);
      chk("clk toggle", 10'h3ff, cv ^ sec_bus_clock_out_o ^ (clk_disable_i | mv));
      chk("clk stop", 0, cv & (clk_disable_i | mv));
    end
    $display("level test done");
    // claim delays from never through late, abort pulse five cycles after the frame
    for (k = 0; k < 6; k++) begin
      dly = (k == 0) ? 0 : 1 + {$random(seed)} % 7;
      @(negedge sec_bus_clock_in_i) mst_frame_start_i = 1;
      @(negedge sec_bus_clock_in_i) mst_frame_start_i = 0;
      e = (dly == 0 || dly > ABORT_CYCLES) ? ABORT_CYCLES : -1;
      t = -1;
      for (i = 0; i < 12; i++) begin
        if (master_abort_o === 1'b1 && t < 0) t = i;
        ss(1);
      end
      chk("abort cycle", e, t);
    end
    $display("abort test done");
    mst_active_i = 1;
    sec_irdy_n_i = 0;
    @(negedge sec_bus_clock_in_i) sec_stop_n_i = 0;
    @(negedge sec_bus_clock_in_i) sec_stop_n_i = 1;
    chk("terminate", 1, mst_terminate_o);
    mst_active_i = 0;
    sec_irdy_n_i = 1;
    // one-cycle request on claim, stop and lock in turn
    for (k = 0; k < 3; k++) begin
      @(negedge sec_bus_clock_in_i) {tgt_claim_i, tgt_stop_i, mst_lock_i} = 3'b100 >> k;
      @(negedge sec_bus_clock_in_i) {tgt_claim_i, tgt_stop_i, mst_lock_i} = 0;
      chk("turn low", 2'b01, tn(k));
      ss(1);
      chk("turn high", 2'b11, tn(k));
      ss(1);
      chk("turn off", 0, tn(k) & 2'b01);
    end
    $display("turnaround test done");
    // alternate good and bad parity on random data
    for (k = 0; k < 4; k++) begin
      @(negedge sec_bus_clock_in_i) data_rx_i = 1;
      sec_ad_i = $random(seed);
      sec_cmd_byte_en_i = $random(seed);
      @(negedge sec_bus_clock_in_i) data_rx_i = 0;
      sec_parity_i = k[0] ^ (^{sec_ad_i, sec_cmd_byte_en_i});
      ss(2);
      chk("perr", {1'b0, k[0]}, {sec_data_parity_fault_n_o & k[0], sec_data_parity_fault_oe_o});
      sec_ad_i = ~sec_ad_i;
      sec_parity_i = ~sec_parity_i;
      ss(3);
    end
    $display("parity test done");
    // random requester takes the bus, then it parks back on the bridge
    for (k = 0; k < 3; k++) begin
      i = {$random(seed)} % N_REQ;
      @(negedge sec_bus_clock_in_i) sec_req_n_i[i] = 0;
      wt(i);
      chk("grant gap", GNT_GAP_CYCLES, t);
      chk("no park", 0, sec_drive_oe_o);
      @(negedge sec_bus_clock_in_i) sec_req_n_i[i] = 1;
      wt(BRIDGE_IDX);
      chk("park gap", GNT_GAP_CYCLES, t);
      ss(2);
      chk("park drive", 1, sec_drive_oe_o);
    end
    $display("arbiter test done");
    // strap high at secondary reset hands slot zero to an outside arbiter
    sec_central_function_strap_n_i = 1;
    sec_reset_sw_i = 1;
    ss(5);
    sec_reset_sw_i = 0;
    ss(5);
    for (k = 0; k < 4; k++) begin
      {bridge_req_i, sec_req_n_i[0]} = $random(seed);
      ss(2);
      chk("ext request", {8'hff, !bridge_req_i}, sec_gnt_n_o);
      chk("ext grant", !sec_req_n_i[0], bridge_gnt_o);
    end
    $display("external arbiter test done");
    test_done;
  end
endmodule // test_secondary_bus_port_control
